/* File: common/ctb_cfg.svh */
// constants for the counter/timer and baud generator clocking block
`ifndef CTB_CFG_SVH
`define CTB_CFG_SVH

// register indices, byte address is index * 4
`define CTB_IDX_AUX_CTRL 8'h04
`define CTB_IDX_CT0_PRE_HI 8'h16
`define CTB_IDX_CT0_PRE_LO 8'h17
`define CTB_IDX_CT1_PRE_HI 8'h1E
`define CTB_IDX_CT1_PRE_LO 8'h1F
`define CTB_IDX_CT0_SRC 8'h24
`define CTB_IDX_DIV_LO 8'h26
`define CTB_IDX_DIV_HI 8'h27
`define CTB_IDX_CT1_SRC 8'h2C
`define CTB_IDX_BRG_CTRL 8'h33

// bus and field layout
`define CTB_ADDR_W 10
`define CTB_BYTE_W 8
`define CTB_SRC_W 6
`define CTB_BRG_CTRL_W 4
`define CTB_BRG_RUN_BIT 3

// counter/timer clock select codes
`define CTB_SEL_PIN 4'h0
`define CTB_SEL_PIN16 4'h1
`define CTB_SEL_SYS1 4'h2
`define CTB_SEL_SYS2 4'h3
`define CTB_SEL_SYS16 4'h4
`define CTB_SEL_SYS32 4'h5
`define CTB_SEL_SYS64 4'h6
`define CTB_SEL_SYS128 4'h7
`define CTB_SEL_TX1X 4'h8
`define CTB_SEL_RXLOAD 4'hC

// baud generator clock select codes
`define CTB_BSEL_SYS1 3'h0
`define CTB_BSEL_SYS2 3'h1
`define CTB_BSEL_SYS16 3'h2
`define CTB_BSEL_SYS32 3'h3
`define CTB_BSEL_SYS64 3'h4
`define CTB_BSEL_SYS128 3'h5
`define CTB_BSEL_PIN 3'h6

// prescaler taps: top bit of the all-ones window
`define CTB_PRE_W 7
`define CTB_PRE_MSB2 0
`define CTB_PRE_MSB16 3
`define CTB_PRE_MSB32 4
`define CTB_PRE_MSB64 5
`define CTB_PRE_MSB128 6

// divide-by-16 last states and terminal count
`define CTB_DIV16_LAST 4'hF
`define CTB_CNT_TERM 16'h0001

// reset values
`define CTB_RST_SRC 6'h00
`define CTB_RST_AUX 6'h00
`define CTB_RST_DIV 16'h0000
`define CTB_RST_PRESET 16'h0000
`define CTB_RST_BRG_CTRL 4'h0

`endif

/* File: common/ctb_pkg.sv */
// types shared by the counter/timer and baud generator clocking block
package ctb_pkg;

  typedef enum logic [1:0] {
    CTB_MODE_COUNTER = 2'h0,
    CTB_MODE_TIMER = 2'h1,
    CTB_MODE_RSVD = 2'h2,
    CTB_MODE_PULSE = 2'h3
  } ctb_mode_e;

  // mode and clock select of one counter/timer
  typedef struct packed {
    ctb_mode_e mode;
    logic [3:0] clksel;
  } ctb_ctrl_s;

  // per-cycle command to one counter/timer unit
  typedef struct packed {
    logic load;
    logic tick;
    ctb_mode_e mode;
    logic [15:0] preset;
  } ctb_ct_cfg_s;

endpackage : ctb_pkg

/* File: logic/ctb_ct_unit.sv */
// one 16-bit counter/timer: counter, square-wave and pulse modes
`timescale 1ns/1ps
`include "ctb_cfg.svh"

module ctb_ct_unit
  import ctb_pkg::*;
(
  input wire logic mclk,
  input wire logic srst,
  input wire ctb_ct_cfg_s cfg,
  output logic [15:0] count,
  output logic out
);

  typedef struct packed {
    logic [15:0] count;
    logic out;
  } ctb_unit_s;

  ctb_unit_s st_reg;
  ctb_unit_s st_next;
  logic term;

  assign term = (st_reg.count <= `CTB_CNT_TERM);

  // next state of the down counter and its output
  always_comb begin
    st_next = st_reg;
    if (cfg.load) begin
      st_next.count = cfg.preset;
      st_next.out = 1'b0;
    end else if (cfg.tick) begin
      // RL12: reload every preset ticks
      st_next.count = term ? cfg.preset : st_reg.count - 16'h0001;
      unique case (cfg.mode)
        // RL4: counter sets edge
        CTB_MODE_COUNTER: st_next.out = st_reg.out | term;
        // RL5: toggle for square wave
        CTB_MODE_TIMER: st_next.out = term ? ~st_reg.out : st_reg.out;
        // RL6: one pulse per preset
        // RL7: high one input period
        CTB_MODE_PULSE: st_next.out = term;
        CTB_MODE_RSVD: st_next.out = st_reg.out;
      endcase
    end
  end

  // state register
  always_ff @(posedge mclk) begin
    if (srst) begin
      st_reg <= '{count: `CTB_RST_PRESET, out: 1'b0};
    end else begin
      st_reg <= st_next;
    end
  end

  assign count = st_reg.count;
  assign out = st_reg.out;

  property p_square;
    @(posedge mclk) disable iff (srst)
    (cfg.tick && !cfg.load && cfg.mode == CTB_MODE_TIMER && term)
      |=> (out != $past(out)) && (count == $past(cfg.preset));
  endproperty
  a_square: assert property (p_square) else $error("square wave missed toggle"); // RL12

  property p_timer_hold;
    @(posedge mclk) disable iff (srst)
    (cfg.tick && !cfg.load && cfg.mode == CTB_MODE_TIMER && !term) |=> $stable(out);
  endproperty
  a_timer_hold: assert property (p_timer_hold) else $error("timer toggled early"); // RL5

  property p_pulse_width;
    @(posedge mclk) disable iff (srst)
    (cfg.tick && !cfg.load && cfg.mode == CTB_MODE_PULSE && !term) |=> !out;
  endproperty
  a_pulse_width: assert property (p_pulse_width) else $error("pulse too long"); // RL7

  property p_pulse_rate;
    @(posedge mclk) disable iff (srst)
    (cfg.tick && !cfg.load && cfg.mode == CTB_MODE_PULSE && term) |=> out;
  endproperty
  a_pulse_rate: assert property (p_pulse_rate) else $error("pulse missing"); // RL6

  property p_counter_edge;
    @(posedge mclk) disable iff (srst)
    (cfg.tick && !cfg.load && cfg.mode == CTB_MODE_COUNTER && term) |=> out;
  endproperty
  a_counter_edge: assert property (p_counter_edge) else $error("no counter edge"); // RL4

endmodule : ctb_ct_unit

/* File: logic/ctb_top.sv */
// apb registers and clock selection for two counter/timers and the baud generator
//
// The APB register port was decided locally.
`timescale 1ns/1ps
`include "ctb_cfg.svh"

// Overview of operation
// RL1: divisor high byte register feeds generator
// RL2: divisor low byte register completes divisor
// RL3: two counter/timers, separate source registers
// RL4: mode 00 counts and gives edge
// RL5: mode 01 gives continuous square wave
// RL6: mode 11 pulses at double rate
// RL7: pulse lasts one input clock period
// RL8: clock select picks pin, prescale, tx
// RL9: code 1100 counts receive loads; reserved
// RL10: source write overrides auxiliary control
// RL11: generator divides; users divide sixteen more
// RL12: square wave period twice the preset
// RL13: preset registers write-only, reads show count
// RL14: run bit low holds generator reset
// RL15: generator reloads divisor at terminal count
// RL16: reserved codes stop clocking, hold count
module ctb_top
  import ctb_pkg::*;
(
  input wire logic mclk,
  input wire logic srst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [`CTB_ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic ct0_ext_clock_pin,
  input wire logic ct1_ext_clock_pin,
  input wire logic brg_ext_clock_pin,
  input wire logic transmitter_1x_clock,
  input wire logic rx_fifo_load,
  output logic ct0_out,
  output logic ct1_out,
  output logic brg_16x_tick,
  output logic brg_1x_tick
);

  typedef struct packed {
    logic [2:0][2:0] pin_sync;
    logic [2:0] pin_lvl;
    logic [1:0][3:0] ext_div;
    ctb_ctrl_s [1:0] ct_src;
    logic [1:0][15:0] ct_preset;
    logic [1:0] ct_own;
    ctb_ctrl_s aux;
    logic [15:0] divisor;
    logic [`CTB_BRG_CTRL_W-1:0] brg_ctrl;
    logic [`CTB_PRE_W-1:0] prescale;
    logic tx1x_d;
    logic [15:0] brg_cnt;
    logic [3:0] brg_sub;
    logic brg_tick;
    logic rxtx_tick;
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
  } ctb_top_s;

  ctb_top_s st_reg;
  ctb_top_s st_next;
  logic [2:0] pin_in;
  logic [2:0] pin_edge;
  logic [1:0] ext16_edge;
  logic [`CTB_PRE_W-1:0] pre;
  logic [5:0] sys_en;
  logic tx_edge;
  logic setup;
  logic wr_fire;
  logic [7:0] idx;
  logic mapped;
  logic [1:0] src_wr;
  logic [1:0] pre_wr;
  ctb_ctrl_s [1:0] ct_eff;
  logic [1:0] ct_tick;
  ctb_ct_cfg_s [1:0] ct_cfg;
  logic [1:0][15:0] ct_count;
  logic [1:0] ct_out;
  logic brg_en;
  logic brg_run;
  logic [7:0] wbyte;
  logic [31:0] rdata;

  assign pin_in = {brg_ext_clock_pin, ct1_ext_clock_pin, ct0_ext_clock_pin};
  assign pre = st_reg.prescale;
  assign wbyte = pwdata[`CTB_BYTE_W-1:0];

  // rising edges of the filtered pin levels, from registered stages only
  always_comb begin
    for (int p = 0; p < 3; p++) begin
      pin_edge[p] = st_reg.pin_sync[p][1] & st_reg.pin_sync[p][2] & ~st_reg.pin_lvl[p];
    end
  end
  assign tx_edge = transmitter_1x_clock & ~st_reg.tx1x_d;

  // system clock enables for /1, /2, /16, /32, /64, /128
  assign sys_en = {&pre[`CTB_PRE_MSB128:0], &pre[`CTB_PRE_MSB64:0], &pre[`CTB_PRE_MSB32:0],
                   &pre[`CTB_PRE_MSB16:0], pre[`CTB_PRE_MSB2], 1'b1};

  // apb decode, one wait-free access phase
  assign setup = psel & ~penable;
  assign wr_fire = psel & penable & st_reg.pready & pwrite;
  assign idx = paddr[`CTB_ADDR_W-1:2];

  always_comb begin
    mapped = 1'b0;
    if (paddr[1:0] == 2'h0) begin
      unique case (idx)
        `CTB_IDX_AUX_CTRL, `CTB_IDX_CT0_PRE_HI, `CTB_IDX_CT0_PRE_LO,
        `CTB_IDX_CT1_PRE_HI, `CTB_IDX_CT1_PRE_LO, `CTB_IDX_CT0_SRC,
        `CTB_IDX_DIV_LO, `CTB_IDX_DIV_HI, `CTB_IDX_CT1_SRC,
        `CTB_IDX_BRG_CTRL: mapped = 1'b1;
        default: mapped = 1'b0;
      endcase
    end
  end

  // RL3: separate source registers
  assign src_wr[0] = wr_fire & mapped & (idx == `CTB_IDX_CT0_SRC);
  assign src_wr[1] = wr_fire & mapped & (idx == `CTB_IDX_CT1_SRC);
  assign pre_wr[0] = wr_fire & mapped &
                     ((idx == `CTB_IDX_CT0_PRE_HI) | (idx == `CTB_IDX_CT0_PRE_LO));
  assign pre_wr[1] = wr_fire & mapped &
                     ((idx == `CTB_IDX_CT1_PRE_HI) | (idx == `CTB_IDX_CT1_PRE_LO));

  // counter/timer clock select, reserved codes give no tick
  function automatic logic ct_sel_tick(input logic [3:0] sel, input logic pin,
                                       input logic pin16, input logic tx,
                                       input logic rxld, input logic [5:0] sys);
    logic t;
    t = 1'b0;
    case (sel)
      `CTB_SEL_PIN: t = pin;
      `CTB_SEL_PIN16: t = pin16;
      `CTB_SEL_SYS1: t = sys[0];
      `CTB_SEL_SYS2: t = sys[1];
      `CTB_SEL_SYS16: t = sys[2];
      `CTB_SEL_SYS32: t = sys[3];
      `CTB_SEL_SYS64: t = sys[4];
      `CTB_SEL_SYS128: t = sys[5];
      `CTB_SEL_TX1X: t = tx;
      // RL9: receive loads counted
      `CTB_SEL_RXLOAD: t = rxld;
      default: t = 1'b0;
    endcase
    return t;
  endfunction : ct_sel_tick

  // baud generator clock select
  function automatic logic brg_sel_tick(input logic [2:0] sel, input logic pin,
                                        input logic [5:0] sys);
    logic t;
    t = 1'b0;
    case (sel)
      `CTB_BSEL_SYS1: t = sys[0];
      `CTB_BSEL_SYS2: t = sys[1];
      `CTB_BSEL_SYS16: t = sys[2];
      `CTB_BSEL_SYS32: t = sys[3];
      `CTB_BSEL_SYS64: t = sys[4];
      `CTB_BSEL_SYS128: t = sys[5];
      `CTB_BSEL_PIN: t = pin;
      default: t = 1'b0;
    endcase
    return t;
  endfunction : brg_sel_tick

  // per-unit source, tick and command
  always_comb begin
    for (int i = 0; i < 2; i++) begin
      ext16_edge[i] = pin_edge[i] & (st_reg.ext_div[i] == `CTB_DIV16_LAST);
      // RL10: own source overrides auxiliary
      ct_eff[i] = st_reg.ct_own[i] ? st_reg.ct_src[i] : st_reg.aux;
      // RL8: pick the input clock
      ct_tick[i] = ct_sel_tick(ct_eff[i].clksel, pin_edge[i], ext16_edge[i], tx_edge,
                               rx_fifo_load, sys_en);
      // RL16: reserved mode never ticks
      if (ct_eff[i].mode == CTB_MODE_RSVD) begin
        ct_tick[i] = 1'b0;
      end
      ct_cfg[i].load = src_wr[i] | pre_wr[i];
      ct_cfg[i].tick = ct_tick[i];
      ct_cfg[i].mode = ct_eff[i].mode;
      ct_cfg[i].preset = st_next.ct_preset[i]; // byte written now reloads at once
    end
  end

  // the two counter/timers
  genvar g;
  generate
    for (g = 0; g < 2; g++) begin : g_ct
      ctb_ct_unit u_ct (
        .mclk(mclk),
        .srst(srst),
        .cfg(ct_cfg[g]),
        .count(ct_count[g]),
        .out(ct_out[g])
      );
    end
  endgenerate

  // read data mux, captured in the setup cycle
  always_comb begin
    rdata = 32'h0000_0000;
    unique case (idx)
      `CTB_IDX_AUX_CTRL: rdata[`CTB_SRC_W-1:0] = st_reg.aux;
      // RL13: preset reads show live count
      `CTB_IDX_CT0_PRE_HI: rdata[7:0] = ct_count[0][15:8];
      `CTB_IDX_CT0_PRE_LO: rdata[7:0] = ct_count[0][7:0];
      `CTB_IDX_CT1_PRE_HI: rdata[7:0] = ct_count[1][15:8];
      `CTB_IDX_CT1_PRE_LO: rdata[7:0] = ct_count[1][7:0];
      `CTB_IDX_CT0_SRC: rdata[`CTB_SRC_W-1:0] = st_reg.ct_src[0];
      `CTB_IDX_DIV_LO: rdata[7:0] = st_reg.divisor[7:0];
      `CTB_IDX_DIV_HI: rdata[7:0] = st_reg.divisor[15:8];
      `CTB_IDX_CT1_SRC: rdata[`CTB_SRC_W-1:0] = st_reg.ct_src[1];
      `CTB_IDX_BRG_CTRL: rdata[`CTB_BRG_CTRL_W-1:0] = st_reg.brg_ctrl;
      default: rdata = 32'h0000_0000;
    endcase
    if (!mapped) begin
      rdata = 32'h0000_0000;
    end
  end

  assign brg_run = st_reg.brg_ctrl[`CTB_BRG_RUN_BIT];
  assign brg_en = brg_sel_tick(st_reg.brg_ctrl[2:0], pin_edge[2], sys_en);

  // next state of the whole block
  always_comb begin
    st_next = st_reg;
    // three-stage pin filter, level taken when stages two and three agree
    for (int p = 0; p < 3; p++) begin
      st_next.pin_sync[p] = {st_reg.pin_sync[p][1:0], pin_in[p]};
      if (st_reg.pin_sync[p][1] == st_reg.pin_sync[p][2]) begin
        st_next.pin_lvl[p] = st_reg.pin_sync[p][2];
      end
    end
    for (int i = 0; i < 2; i++) begin
      if (pin_edge[i]) begin
        st_next.ext_div[i] = st_reg.ext_div[i] + 4'h1;
      end
    end
    st_next.prescale = st_reg.prescale + 7'h01;
    st_next.tx1x_d = transmitter_1x_clock;

    // apb handshake: answer in the cycle after setup
    st_next.pready = setup;
    st_next.pslverr = setup & ~mapped;
    st_next.prdata = (setup & ~pwrite) ? rdata : 32'h0000_0000;

    if (wr_fire & mapped) begin
      unique case (idx)
        `CTB_IDX_AUX_CTRL: st_next.aux = wbyte[`CTB_SRC_W-1:0];
        `CTB_IDX_CT0_PRE_HI: st_next.ct_preset[0][15:8] = wbyte;
        `CTB_IDX_CT0_PRE_LO: st_next.ct_preset[0][7:0] = wbyte;
        `CTB_IDX_CT1_PRE_HI: st_next.ct_preset[1][15:8] = wbyte;
        `CTB_IDX_CT1_PRE_LO: st_next.ct_preset[1][7:0] = wbyte;
        `CTB_IDX_CT0_SRC: begin
          st_next.ct_src[0] = wbyte[`CTB_SRC_W-1:0];
          st_next.ct_own[0] = 1'b1;
        end
        // RL2: low divisor byte
        `CTB_IDX_DIV_LO: st_next.divisor[7:0] = wbyte;
        // RL1: high divisor byte
        `CTB_IDX_DIV_HI: st_next.divisor[15:8] = wbyte;
        `CTB_IDX_CT1_SRC: begin
          st_next.ct_src[1] = wbyte[`CTB_SRC_W-1:0];
          st_next.ct_own[1] = 1'b1;
        end
        `CTB_IDX_BRG_CTRL: st_next.brg_ctrl = wbyte[`CTB_BRG_CTRL_W-1:0];
        default: st_next.aux = st_reg.aux;
      endcase
    end

    // baud generator
    st_next.brg_tick = 1'b0;
    st_next.rxtx_tick = 1'b0;
    if (!brg_run) begin
      // RL14: held reset while stopped
      st_next.brg_cnt = st_reg.divisor;
      st_next.brg_sub = 4'h0;
    end else if (brg_en) begin
      if (st_reg.brg_cnt <= `CTB_CNT_TERM) begin
        // RL15: reload at terminal count
        st_next.brg_cnt = st_reg.divisor;
        st_next.brg_tick = 1'b1;
        // RL11: further divide by sixteen
        st_next.brg_sub = st_reg.brg_sub + 4'h1;
        st_next.rxtx_tick = (st_reg.brg_sub == `CTB_DIV16_LAST);
      end else begin
        st_next.brg_cnt = st_reg.brg_cnt - 16'h0001;
      end
    end
  end

  // state register
  always_ff @(posedge mclk) begin
    if (srst) begin
      st_reg <= '0;
      st_reg.ct_src <= {`CTB_RST_SRC, `CTB_RST_SRC};
      st_reg.ct_preset <= {`CTB_RST_PRESET, `CTB_RST_PRESET};
      st_reg.aux <= `CTB_RST_AUX;
      st_reg.divisor <= `CTB_RST_DIV;
      st_reg.brg_ctrl <= `CTB_RST_BRG_CTRL;
      st_reg.brg_cnt <= `CTB_RST_DIV;
    end else begin
      st_reg <= st_next;
    end
  end

  // outputs straight from flops
  assign prdata = st_reg.prdata;
  assign pready = st_reg.pready;
  assign pslverr = st_reg.pslverr;
  assign ct0_out = ct_out[0];
  assign ct1_out = ct_out[1];
  assign brg_16x_tick = st_reg.brg_tick;
  assign brg_1x_tick = st_reg.rxtx_tick;

  sequence s_write(logic [7:0] a);
    psel && penable && pready && pwrite && paddr[1:0] == 2'h0 && idx == a;
  endsequence

  property p_div_hi;
    @(posedge mclk) disable iff (srst)
    s_write(`CTB_IDX_DIV_HI) |=> st_reg.divisor[15:8] == $past(pwdata[7:0])
      && $stable(st_reg.divisor[7:0]);
  endproperty
  a_div_hi: assert property (p_div_hi) else $error("divisor high byte not stored"); // RL1

  property p_div_lo;
    @(posedge mclk) disable iff (srst)
    s_write(`CTB_IDX_DIV_LO) |=> st_reg.divisor[7:0] == $past(pwdata[7:0])
      && $stable(st_reg.divisor[15:8]);
  endproperty
  a_div_lo: assert property (p_div_lo) else $error("divisor low byte not stored"); // RL2

  property p_src_sep;
    @(posedge mclk) disable iff (srst)
    s_write(`CTB_IDX_CT1_SRC) |=> st_reg.ct_src[1] == $past(pwdata[5:0])
      && $stable(st_reg.ct_src[0]);
  endproperty
  a_src_sep: assert property (p_src_sep) else $error("source registers not separate"); // RL3

  property p_override;
    @(posedge mclk) disable iff (srst)
    s_write(`CTB_IDX_CT0_SRC) |=> st_reg.ct_own[0] ##1 ct_eff[0] == st_reg.ct_src[0];
  endproperty
  a_override: assert property (p_override) else $error("source write did not override"); // RL10

  property p_sel_sys;
    @(posedge mclk) disable iff (srst)
    (ct_eff[0].clksel == `CTB_SEL_SYS1 && ct_eff[0].mode != CTB_MODE_RSVD) |-> ct_tick[0];
  endproperty
  a_sel_sys: assert property (p_sel_sys) else $error("system clock select missed tick"); // RL8

  property p_sel_rx;
    @(posedge mclk) disable iff (srst)
    (ct_eff[1].clksel == `CTB_SEL_RXLOAD && ct_eff[1].mode != CTB_MODE_RSVD)
      |-> ct_tick[1] == rx_fifo_load;
  endproperty
  a_sel_rx: assert property (p_sel_rx) else $error("receive load not counted"); // RL9

  property p_reserved;
    @(posedge mclk) disable iff (srst)
    (ct_eff[0].mode == CTB_MODE_RSVD && !ct_cfg[0].load) |=> $stable(ct_count[0]);
  endproperty
  a_reserved: assert property (p_reserved) else $error("reserved mode moved count"); // RL16

  property p_brg_stop;
    @(posedge mclk) disable iff (srst)
    (!brg_run)[*2] |-> !brg_16x_tick && st_reg.brg_cnt == $past(st_reg.divisor);
  endproperty
  a_brg_stop: assert property (p_brg_stop) else $error("stopped generator ran"); // RL14

  property p_brg_reload;
    @(posedge mclk) disable iff (srst)
    (brg_run && brg_en && st_reg.brg_cnt <= `CTB_CNT_TERM)
      |=> brg_16x_tick && st_reg.brg_cnt == $past(st_reg.divisor);
  endproperty
  a_brg_reload: assert property (p_brg_reload) else $error("generator did not reload"); // RL15

  property p_rxtx;
    @(posedge mclk) disable iff (srst)
    brg_1x_tick |-> brg_16x_tick && st_reg.brg_sub == 4'h0;
  endproperty
  a_rxtx: assert property (p_rxtx) else $error("1x tick not on sixteenth"); // RL11

  property p_preset_wo;
    @(posedge mclk) disable iff (srst)
    (setup && !pwrite && paddr[1:0] == 2'h0 && idx == `CTB_IDX_CT0_PRE_LO)
      |=> prdata[7:0] == $past(ct_count[0][7:0]) && prdata[31:8] == 24'h00_0000;
  endproperty
  a_preset_wo: assert property (p_preset_wo) else $error("preset read not the count"); // RL13

endmodule : ctb_top

/* File: tb/tb_ctb_top.sv */
// self-checking bench for the counter/timer and baud generator block
`timescale 1ns/1ps
`include "ctb_cfg.svh"

module tb_ctb_top
  import ctb_pkg::*;
;
  typedef struct packed {
    logic wr;
    logic [9:0] addr;
    logic [7:0] wd;
    logic [7:0] rd;
    logic err;
  } ctb_row_s;

  logic mclk = 1'b0;
  logic srst = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [`CTB_ADDR_W-1:0] paddr = 10'h000;
  logic [31:0] pwdata = 32'h0000_0000;
  logic ct0_ext_clock_pin = 1'b0;
  logic ct1_ext_clock_pin = 1'b0;
  logic brg_ext_clock_pin = 1'b0;
  logic transmitter_1x_clock = 1'b0;
  logic rx_fifo_load = 1'b0;
  logic [31:0] prdata;
  logic pready, pslverr, ct0_out, ct1_out, brg_16x_tick, brg_1x_tick;
  logic [3:0] obs;
  int err_count = 0;
  int compares = 0;
  int cyc = 0;
  ctb_row_s rows [11];
  logic [3:0] sel_tab [10] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h4, 4'h5, 4'h6, 4'h7, 4'h8, 4'hC};
  int per_tab [10] = '{40, 640, 2, 4, 32, 64, 128, 256, 16, 10};
  logic [7:0] rsv_tab [7] = '{8'h22, 8'h19, 8'h1A, 8'h1B, 8'h1D, 8'h1E, 8'h1F};
  logic [7:0] rst_tab [6] = '{8'h24, 8'h2C, 8'h26, 8'h27, 8'h04, 8'h33};
  logic [7:0] bctl_tab [4] = '{8'h08, 8'h09, 8'h08, 8'h0E};
  logic [15:0] bdiv_tab [4] = '{16'h0003, 16'h0003, 16'h0100, 16'h0003};
  int bper_tab [4] = '{3, 6, 256, 42};

  ctb_top dut (.mclk(mclk), .srst(srst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .ct0_ext_clock_pin(ct0_ext_clock_pin), .ct1_ext_clock_pin(ct1_ext_clock_pin),
    .brg_ext_clock_pin(brg_ext_clock_pin), .transmitter_1x_clock(transmitter_1x_clock),
    .rx_fifo_load(rx_fifo_load), .ct0_out(ct0_out), .ct1_out(ct1_out),
    .brg_16x_tick(brg_16x_tick), .brg_1x_tick(brg_1x_tick));

  assign obs = {brg_1x_tick, brg_16x_tick, ct1_out, ct0_out};

  // 40 MHz clock
  initial begin
    forever #12.5 mclk = ~mclk;
  end

  // free-running pin and strobe patterns
  always @(posedge mclk) begin
    cyc <= cyc + 1;
    ct0_ext_clock_pin <= (cyc % 20) < 10;
    ct1_ext_clock_pin <= (cyc % 12) < 6;
    brg_ext_clock_pin <= (cyc % 14) < 7;
    transmitter_1x_clock <= (cyc % 8) < 4;
    rx_fifo_load <= (cyc % 5) == 0;
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string msg);
    compares++;
    if (seen !== exp) begin
      err_count++;
      $display("wrong value at %0t: %s seen %h expected %h", $time, msg, seen, exp);
    end
  endtask : chk

  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", compares, err_count);
    if (err_count == 0 && compares > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : end_of_test

  function automatic logic [9:0] ba(input logic [7:0] idx);
    return {idx, 2'b00};
  endfunction : ba

  // one apb transfer, entered just after a rising edge, ends one idle edge later
  task automatic apb(input logic w, input logic [9:0] a, input logic [7:0] d,
                     output logic [31:0] rd, output logic er);
    int n;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h00_0000, d};
    @(posedge mclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge mclk);
      n++;
    end while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    chk(n, 1, "ready latency");
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge mclk);
  endtask : apb

  task automatic wr(input logic [7:0] idx, input logic [7:0] d);
    logic [31:0] r;
    logic e;
    apb(1'b1, ba(idx), d, r, e);
  endtask : wr

  task automatic rdc(input logic [7:0] idx, input logic [7:0] x, input string m);
    logic [31:0] r;
    logic e;
    apb(1'b0, ba(idx), 8'h00, r, e);
    chk(r, {24'h00_0000, x}, m);
  endtask : rdc

  // time one full period of an observed output, rise to rise
  task automatic meas(input int u, output int hi, output int per);
    logic prev;
    logic cur;
    int n;
    int st;
    prev = 1'b1;
    n = 0;
    st = 0;
    hi = 0;
    per = 0;
    while (st < 2 && n < 3000) begin
      @(posedge mclk);
      n++;
      cur = obs[u];
      if (cur === 1'b1 && prev === 1'b0) st++;
      if (st == 1) begin
        per++;
        if (cur === 1'b1) hi++;
      end
      prev = cur;
    end
  endtask : meas

  // watchdog against a hang
  initial begin
    repeat (40000) @(posedge mclk);
    err_count++;
    end_of_test();
  end

  // main sequence
  initial begin
    int hi, per, n;
    logic [31:0] r;
    logic e;
    rows = '{'{1'b1, ba(8'h26), 8'hA5, 8'h00, 1'b0}, '{1'b0, ba(8'h26), 8'h00, 8'hA5, 1'b0},
      '{1'b1, ba(8'h27), 8'h3C, 8'h00, 1'b0}, '{1'b0, ba(8'h27), 8'h00, 8'h3C, 1'b0},
      '{1'b1, ba(8'h24), 8'hFF, 8'h00, 1'b0}, '{1'b0, ba(8'h24), 8'h00, 8'h3F, 1'b0},
      '{1'b1, ba(8'h04), 8'hC5, 8'h00, 1'b0}, '{1'b0, ba(8'h04), 8'h00, 8'h05, 1'b0},
      '{1'b1, ba(8'h05), 8'h77, 8'h00, 1'b1}, '{1'b0, 10'h099, 8'h00, 8'h00, 1'b1},
      '{1'b0, ba(8'h30), 8'h00, 8'h00, 1'b1}};
    repeat (4) @(posedge mclk);
    chk(obs, 4'h0, "outputs in reset");
    repeat (4) @(posedge mclk);
    srst <= 1'b0;
    foreach (rst_tab[i]) rdc(rst_tab[i], 8'h00, "reset value");
    foreach (rows[i]) begin
      apb(rows[i].wr, rows[i].addr, rows[i].wd, r, e);
      chk(r, {24'h00_0000, rows[i].rd}, "row read data");
      chk(e, rows[i].err, "row error flag");
    end
    // ct1 follows aux control until its own source is written
    wr(`CTB_IDX_CT1_PRE_HI, 8'h00);
    wr(`CTB_IDX_CT1_PRE_LO, 8'h01);
    wr(`CTB_IDX_AUX_CTRL, {2'b00, CTB_MODE_TIMER, `CTB_SEL_SYS1});
    meas(1, hi, per);
    chk(per, 2, "ct1 from aux");
    wr(`CTB_IDX_CT1_SRC, {2'b00, CTB_MODE_TIMER, `CTB_SEL_SYS2});
    meas(1, hi, per);
    chk(per, 4, "ct1 own source");
    wr(`CTB_IDX_AUX_CTRL, {2'b00, CTB_MODE_TIMER, `CTB_SEL_SYS1});
    meas(1, hi, per);
    chk(per, 4, "aux ignored after source write");
    wr(`CTB_IDX_CT1_SRC, {2'b00, CTB_MODE_TIMER, `CTB_SEL_PIN});
    meas(1, hi, per);
    chk(per, 24, "ct1 pin clock");
    // every clock select in timer mode, preset 1
    wr(`CTB_IDX_CT0_PRE_HI, 8'h00);
    wr(`CTB_IDX_CT0_PRE_LO, 8'h01);
    foreach (sel_tab[i]) begin
      wr(`CTB_IDX_CT0_SRC, {2'b00, CTB_MODE_TIMER, sel_tab[i]});
      meas(0, hi, per);
      chk(per, per_tab[i], "timer period");
      chk(hi, per_tab[i] / 2, "timer high time");
    end
    // square wave versus pulse, preset 3 on sys/2
    wr(`CTB_IDX_CT0_PRE_LO, 8'h03);
    wr(`CTB_IDX_CT0_SRC, {2'b00, CTB_MODE_TIMER, `CTB_SEL_SYS2});
    meas(0, hi, per);
    chk(per, 12, "square period");
    wr(`CTB_IDX_CT0_SRC, {2'b00, CTB_MODE_PULSE, `CTB_SEL_SYS2});
    meas(0, hi, per);
    chk(per, 6, "pulse period");
    chk(hi, 2, "pulse width");
    // counter mode edge is sticky
    wr(`CTB_IDX_CT0_PRE_LO, 8'h05);
    wr(`CTB_IDX_CT0_SRC, {2'b00, CTB_MODE_COUNTER, `CTB_SEL_SYS1});
    @(posedge mclk);
    chk(ct0_out, 1'b0, "counter before terminal");
    repeat (20) @(posedge mclk);
    chk(ct0_out, 1'b1, "counter edge");
    repeat (40) @(posedge mclk);
    chk(ct0_out, 1'b1, "counter edge held");
    // reserved codes hold the count; a preset byte write reloads the new preset
    wr(`CTB_IDX_CT0_SRC, 8'h22);
    wr(`CTB_IDX_CT0_PRE_HI, 8'h12);
    wr(`CTB_IDX_CT0_PRE_LO, 8'h34);
    rdc(`CTB_IDX_CT0_PRE_LO, 8'h34, "reload from new preset");
    foreach (rsv_tab[i]) begin
      wr(`CTB_IDX_CT0_SRC, rsv_tab[i]);
      repeat (40) @(posedge mclk);
      rdc(`CTB_IDX_CT0_PRE_LO, 8'h34, "held count low");
      rdc(`CTB_IDX_CT0_PRE_HI, 8'h12, "held count high");
      chk(ct0_out, 1'b0, "output held");
    end
    // preset is not read back once counting
    wr(`CTB_IDX_CT0_SRC, {2'b00, CTB_MODE_TIMER, `CTB_SEL_SYS1});
    repeat (300) @(posedge mclk);
    apb(1'b0, ba(`CTB_IDX_CT0_PRE_HI), 8'h00, r, e);
    chk(r[7:0] !== 8'h12, 1'b1, "preset readable");
    // baud generator divisor and clock select
    foreach (bctl_tab[i]) begin
      wr(`CTB_IDX_BRG_CTRL, 8'h00);
      wr(`CTB_IDX_DIV_LO, bdiv_tab[i][7:0]);
      wr(`CTB_IDX_DIV_HI, bdiv_tab[i][15:8]);
      wr(`CTB_IDX_BRG_CTRL, bctl_tab[i]);
      meas(2, hi, per);
      chk(per, bper_tab[i], "16x tick spacing");
      if (i == 0) begin
        meas(3, hi, per);
        chk(per, 48, "1x tick spacing");
      end
    end
    wr(`CTB_IDX_BRG_CTRL, 8'h00);
    n = 0;
    repeat (300) begin
      @(posedge mclk);
      if (brg_16x_tick !== 1'b0) n++;
    end
    chk(n, 0, "ticks while stopped");
    // second reset in mid-run
    srst <= 1'b1;
    repeat (2) @(posedge mclk);
    srst <= 1'b0;
    rdc(`CTB_IDX_DIV_HI, 8'h00, "divisor after reset");
    rdc(`CTB_IDX_CT0_SRC, 8'h00, "source after reset");
    end_of_test();
  end
endmodule : tb_ctb_top
